// [hw/pcr_pkg.sv]
`default_nettype none
package pcr_pkg;
   // Register byte offsets on the Wishbone bus.
   localparam logic [7:0] MAP_OFS  = 8'h00;
   localparam logic [7:0] TM2_OFS  = 8'h04;
   localparam logic [7:0] OPT_OFS  = 8'h08;
   localparam logic [7:0] MODE_OFS = 8'h0C;
   localparam logic [7:0] CNT_OFS  = 8'h10;

   // Values after reset.
   localparam logic [7:0] MAP_RESET = 8'h01;
   localparam logic [7:0] TM2_RESET = 8'h00;
   localparam logic [7:0] OPT_RESET = 8'h00;

   // Field positions.
   localparam int RAM_PAGE_LSB = 4;
   localparam int REG_PAGE_LSB = 0;
   localparam int PRESCALE_LSB = 0;
   localparam int WDOG_LSB     = 0;
   localparam int MODE_SPECIAL = 0;
   localparam int MODE_EXP     = 1;
   localparam int MODE_WINDOW  = 2;
   localparam int MODE_USED    = 3;

   // Bits that hold storage; the others read as zero.
   localparam logic [7:0] TM2_KEEP = 8'hF3;
   localparam logic [7:0] OPT_KEEP = 8'hFB;

   // Bus cycles after reset during which protected bits are open.
   localparam logic [6:0] WINDOW_CYCLES = 7'h40;

   // Port-replacement offsets inside the register block.
   localparam logic [5:0] PORT_FIRST = 6'h02;
   localparam logic [5:0] PORT_LAST  = 6'h07;

   // Internal ROM occupies the top 8 Kbytes.
   localparam logic [2:0] ROM_TOP3 = 3'h7;

   // Level of the internal data bus when nothing drives it.
   localparam logic [7:0] FLOAT_DATA = 8'hFF;

   typedef enum logic [1:0] {
      PCR_DIV1  = 2'h0,
      PCR_DIV4  = 2'h1,
      PCR_DIV8  = 2'h2,
      PCR_DIV16 = 2'h3
   } pcr_div_t;

   // Low counter bits that must all be set for one timer count.
   function automatic logic [3:0] pcr_div_mask(input logic [1:0] sel);
      case (pcr_div_t'(sel))
         PCR_DIV1:  pcr_div_mask = 4'h0;
         PCR_DIV4:  pcr_div_mask = 4'h3;
         PCR_DIV8:  pcr_div_mask = 4'h7;
         PCR_DIV16: pcr_div_mask = 4'hF;
         default:   pcr_div_mask = 4'h0;
      endcase
   endfunction : pcr_div_mask

   function automatic logic pcr_is_port(input logic [5:0] ofs);
      pcr_is_port = (ofs >= PORT_FIRST) && (ofs <= PORT_LAST);
   endfunction : pcr_is_port
endpackage : pcr_pkg
`default_nettype wire

// [hw/pcr_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module pcr_decode (
   input  wire logic [15:0] addr_i,
   input  wire logic [3:0]  ram_page_i,
   input  wire logic [3:0]  reg_page_i,
   input  wire logic        expanded_i,
   input  wire logic        rom_enable_i,
   output logic             ram_sel_o,
   output logic             reg_sel_o,
   output logic             rom_sel_o,
   output logic             ext_sel_o
);
   import pcr_pkg::*;

   wire reg_hit  = (addr_i[15:12] == reg_page_i) && (addr_i[11:6] == 6'h00);
   wire ram_hit  = (addr_i[15:12] == ram_page_i) && (addr_i[11:8] == 4'h0);
   wire rom_hit  = rom_enable_i && (addr_i[15:13] == ROM_TOP3);
   wire port_hit = reg_hit && expanded_i && pcr_is_port(addr_i[5:0]);
   wire any_int  = reg_hit || ram_hit || rom_hit;

   // The register block outranks RAM, which outranks ROM.
   assign reg_sel_o = reg_hit && !port_hit;
   assign ram_sel_o = ram_hit && !reg_hit;
   assign rom_sel_o = rom_hit && !reg_hit && !ram_hit;
   // Port offsets go outside even where RAM or ROM overlap.
   assign ext_sel_o = port_hit || (expanded_i && !any_int);
endmodule : pcr_decode
`default_nettype wire

// [hw/pcr_prescale.sv]
`timescale 1ns/1ps
`default_nettype none
module pcr_prescale (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic [1:0] sel_i,
   output logic            tick_o
);
   import pcr_pkg::*;

   logic [3:0] div_cnt;
   wire  [3:0] mask = pcr_div_mask(sel_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt <= 4'h0;
         tick_o  <= 1'b0;
      end else if (ce_i) begin
         div_cnt <= div_cnt + 4'h1;
         tick_o  <= ((div_cnt & mask) == mask);
      end
   end
endmodule : pcr_prescale
`default_nettype wire

// [hw/pcr_top.sv]
// How it works
// - Protected bits take a write only in the first 64 bus cycles and only once.
// - Protected bits sit in the map register, timer mask two and the option register.
// - In special mode the window and once-only limits are lifted.
// - The RAM page field gives the RAM base page and resets to zero.
// - The register page field gives the register block page and resets to 1.
// - RAM page is the upper nibble, register page the lower nibble of the map.
// - Reads of internal resources take internal data, not the external pins.
// - On overlap the register block wins over RAM, and RAM wins over ROM.
// - Unused register offsets read the floating internal bus, RAM and ROM off.
// - In expanded modes register offsets 2 to 7 are external accesses.
// - Bits 3 and 2 of timer mask two read as zero.
// - The prescale field divides the timer clock by 1, 4, 8 or 16.
// - In normal modes the prescale field changes once, inside the window.
// - The watchdog rate bits accept one write inside the window in normal modes.
// - Mode pin B low during reset selects the special mode.
`timescale 1ns/1ps
`default_nettype none
module pcr_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        mode_select_pin_b_i,
   input  wire logic        expanded_mode_pin_i,
   input  wire logic        rom_enable_i,
   input  wire logic [15:0] cpu_addr_i,
   input  wire logic [7:0]  int_data_i,
   input  wire logic        int_drive_i,
   input  wire logic [7:0]  ext_data_i,
   output logic             ram_sel_o,
   output logic             reg_sel_o,
   output logic             rom_sel_o,
   output logic             ext_sel_o,
   output logic      [7:0]  cpu_rdata_o,
   output logic      [3:0]  ram_page_select_o,
   output logic      [3:0]  register_block_page_select_o,
   output logic      [1:0]  timer_prescale_select_o,
   output logic      [1:0]  watchdog_rate_select_o,
   output logic             timer_tick_o,
   output logic             special_mode_select_o,
   output logic             protect_window_o
);
   import pcr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave decode.

   logic [7:0] map_pos;
   logic [7:0] tm2;
   logic [7:0] opt;
   logic [6:0] cyc_cnt;
   logic       win_q;
   logic [2:0] used;
   logic       special;
   logic       expanded;

   wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // A write lands on the edge at which the master sees ack, so a request
   // that is dropped before its answer never touches a register.
   wire bus_wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
   wire wr_map  = bus_wr && (wb_adr_i == MAP_OFS);
   wire wr_tm2  = bus_wr && (wb_adr_i == TM2_OFS);
   wire wr_opt  = bus_wr && (wb_adr_i == OPT_OFS);
   wire wr_mode = bus_wr && (wb_adr_i == MODE_OFS);
   wire window  = win_q;

   // Special mode opens every protected field; otherwise each field needs
   // the window still open and no earlier accepted write.
   wire may_map = special || (window && !used[0]);
   wire may_tm2 = special || (window && !used[1]);
   wire may_opt = special || (window && !used[2]);

   // A refused write simply keeps the old field; the bus still acks.
   wire [7:0] next_map = may_map ? wb_dat_i[7:0] : map_pos;
   wire [1:0] next_pr  = may_tm2 ? wb_dat_i[1:0] : tm2[1:0];
   wire [1:0] next_cr  = may_opt ? wb_dat_i[1:0] : opt[1:0];
   wire [7:0] next_tm2 = ({wb_dat_i[7:2], next_pr}) & TM2_KEEP;
   wire [7:0] next_opt = ({wb_dat_i[7:2], next_cr}) & OPT_KEEP;
   wire [2:0] next_used = used | {wr_opt && may_opt, wr_tm2 && may_tm2,
                                  wr_map && may_map};

   wire [7:0] mode_stat = {2'b00, used, window, expanded, special};

   wire [7:0] rd_byte =
      (wb_adr_i == MAP_OFS)  ? map_pos :
      (wb_adr_i == TM2_OFS)  ? tm2 :
      (wb_adr_i == OPT_OFS)  ? opt :
      (wb_adr_i == MODE_OFS) ? mode_stat :
      (wb_adr_i == CNT_OFS)  ? {1'b0, cyc_cnt} : 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Bus answer: one wait state, ack for a single cycle.

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Protected registers and the bus-cycle window.

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         map_pos <= MAP_RESET;
         tm2     <= TM2_RESET;
         opt     <= OPT_RESET;
         used    <= 3'h0;
         cyc_cnt <= 7'h00;
         win_q   <= 1'b1;
      end else if (ce_i) begin
         if (window) begin
            cyc_cnt <= cyc_cnt + 7'h01;
         end
         // The window is a flop of its own, so the pin that shows it
         // carries no compare behind the counter.
         if (cyc_cnt == WINDOW_CYCLES - 7'h01) begin
            win_q <= 1'b0;
         end
         if (wr_map) begin
            map_pos <= next_map;
         end
         if (wr_tm2) begin
            tm2 <= next_tm2;
         end
         if (wr_opt) begin
            opt <= next_opt;
         end
         used <= next_used;
      end
   end

   // Mode straps are caught while reset is held, from the pins directly.
   // Special mode can only be left by software, never re-entered; any
   // field written before leaving already counts as its single write.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         special  <= !mode_select_pin_b_i;
         expanded <= expanded_mode_pin_i;
      end else if (ce_i && wr_mode) begin
         special <= special && wb_dat_i[MODE_SPECIAL];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Address decode and read data for the processor bus.

   logic ram_hit_c;
   logic reg_hit_c;
   logic rom_hit_c;
   logic ext_hit_c;

   pcr_decode u_decode (
      .addr_i       (cpu_addr_i),
      .ram_page_i   (map_pos[RAM_PAGE_LSB +: 4]),
      .reg_page_i   (map_pos[REG_PAGE_LSB +: 4]),
      .expanded_i   (expanded),
      .rom_enable_i (rom_enable_i),
      .ram_sel_o    (ram_hit_c),
      .reg_sel_o    (reg_hit_c),
      .rom_sel_o    (rom_hit_c),
      .ext_sel_o    (ext_hit_c)
   );

   // External pins feed the core only for external accesses; an internal
   // slot nobody drives shows the floating bus level.
   wire int_any = ram_hit_c || reg_hit_c || rom_hit_c;
   wire [7:0] next_rdata =
      ext_hit_c                  ? ext_data_i :
      (int_any && int_drive_i)   ? int_data_i : FLOAT_DATA;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ram_sel_o   <= 1'b0;
         reg_sel_o   <= 1'b0;
         rom_sel_o   <= 1'b0;
         ext_sel_o   <= 1'b0;
         cpu_rdata_o <= FLOAT_DATA;
      end else if (ce_i) begin
         ram_sel_o   <= ram_hit_c;
         reg_sel_o   <= reg_hit_c;
         rom_sel_o   <= rom_hit_c;
         ext_sel_o   <= ext_hit_c;
         cpu_rdata_o <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Timer prescaler and outputs.

   pcr_prescale u_prescale (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .sel_i  (tm2[PRESCALE_LSB +: 2]),
      .tick_o (timer_tick_o)
   );

   assign ram_page_select_o            = map_pos[RAM_PAGE_LSB +: 4];
   assign register_block_page_select_o = map_pos[REG_PAGE_LSB +: 4];
   assign timer_prescale_select_o      = tm2[PRESCALE_LSB +: 2];
   assign watchdog_rate_select_o       = opt[WDOG_LSB +: 2];
   assign special_mode_select_o        = special;
   assign protect_window_o             = window;

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_map_reset_value: assert property (
      $past(rst_i) |-> map_pos == MAP_RESET)
      else $error("map register not at reset value");

   a_map_late_write: assert property (
      ce_i && wr_map && !special && (!window || used[0]) |=> $stable(map_pos))
      else $error("map register changed outside its window");

   a_special_rewrite: assert property (
      ce_i && wr_map && special |=> map_pos == $past(wb_dat_i[7:0]))
      else $error("special mode write to map register lost");

   a_prescale_locked: assert property (
      !special && !window |=> $stable(tm2[1:0]))
      else $error("prescale field changed after its window");

   a_wdog_locked: assert property (
      !special && used[2] |=> $stable(opt[1:0]))
      else $error("watchdog rate changed after its one write");

   a_tm2_zero_bits: assert property (
      ce_i && bus_req && !wb_we_i && wb_adr_i == TM2_OFS
      |=> wb_ack_o && wb_dat_o[3:2] == 2'b00)
      else $error("timer mask two bits 3 and 2 not zero");

   a_reg_over_ram: assert property (
      reg_sel_o |-> !ram_sel_o && !rom_sel_o)
      else $error("register block overlap not exclusive");

   a_ram_over_rom: assert property (
      ram_sel_o |-> !rom_sel_o)
      else $error("RAM and ROM both selected");

   a_port_external: assert property (
      ce_i && expanded && cpu_addr_i[15:12] == map_pos[3:0]
      && cpu_addr_i[11:6] == 6'h00 && cpu_addr_i[5:0] >= PORT_FIRST
      && cpu_addr_i[5:0] <= PORT_LAST
      |=> ext_sel_o && !ram_sel_o && !rom_sel_o && !reg_sel_o)
      else $error("port offset not taken as external");

   a_internal_data: assert property (
      ce_i && !ext_hit_c && int_any && int_drive_i
      |=> cpu_rdata_o == $past(int_data_i))
      else $error("internal read took external pins");

   a_window_close: assert property (
      ce_i && cyc_cnt == 7'h3F |=> !protect_window_o [*2])
      else $error("protect window not closed at 64 cycles");

   a_ack_single: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   a_ack_answer: assert property (
      ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered in one cycle");

   a_ce_freeze: assert property (
      !ce_i |=> $stable(map_pos) && $stable(tm2) && $stable(opt)
      && $stable(cyc_cnt) && $stable(wb_ack_o))
      else $error("state moved while clock enable was low");

   a_strap_special: assert property (
      $past(rst_i) |-> special_mode_select_o == !$past(mode_select_pin_b_i))
      else $error("special mode does not follow mode pin b");

   a_window_reset: assert property (
      $past(rst_i) |-> protect_window_o && cyc_cnt == 7'h00)
      else $error("protect window not open after reset");

   a_ext_data: assert property (
      ce_i && ext_hit_c |=> cpu_rdata_o == $past(ext_data_i))
      else $error("external access did not take the pins");

   a_float_data: assert property (
      ce_i && int_any && !ext_hit_c && !int_drive_i |=> cpu_rdata_o == FLOAT_DATA)
      else $error("undriven internal slot not read as floating");

   a_tick_div1: assert property (
      ce_i && tm2[1:0] == 2'b00 |=> timer_tick_o)
      else $error("divide by one prescale missed a tick");
endmodule : pcr_top
`default_nettype wire

// [test/pcr_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pcr_core_model (
   input  wire logic        clk_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        drive_i,
   output logic      [15:0] cpu_addr_o,
   output logic      [7:0]  int_data_o,
   output logic             int_drive_o,
   output logic      [7:0]  ext_data_o
);
   ////////////////////////////////////////////////////////////////////////
   // An undriven internal bus shows a pattern that follows the address,
   // so a stale value from the last driven read cannot pass for it.
   always_ff @(posedge clk_i) begin
      cpu_addr_o  <= addr_i;
      int_drive_o <= drive_i;
   end
   assign int_data_o = int_drive_o ? 8'h3C : (cpu_addr_o[7:0] ^ 8'hA5);
   // The outside device keeps driving its pins, so ignoring them is visible.
   assign ext_data_o = 8'h5A;
endmodule : pcr_core_model
`default_nettype wire

// [test/pcr_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pcr_top_tb;
   import pcr_pkg::*;
   localparam int DIV [4] = '{1, 4, 8, 16};
   logic        clk_i  = 1'b0;
   logic        rst_i  = 1'b1;
   logic [7:0]  adr    = 8'h00;
   logic [31:0] wdat   = 32'h0000_0000;
   logic        we     = 1'b0;
   logic        cyc    = 1'b0;
   logic        pinb   = 1'b1;
   logic        pexp   = 1'b0;
   logic        rom_en = 1'b1;
   logic [15:0] paddr  = 16'h0000;
   logic        pdrv   = 1'b0;
   logic        ce     = 1'b1;
   logic [15:0] cpu_addr;
   logic [7:0]  idata, edata, cpu_rdata, rd;
   logic        idrv, wb_ack_o, ram_sel, reg_sel, rom_sel, ext_sel;
   logic [31:0] wb_dat_o;
   logic [3:0]  rpage, gpage;
   logic [1:0]  psel, wsel;
   logic        tick, smode, win;
   int          err_count = 0;
   int          compares  = 0;
   always #10 clk_i = ~clk_i;
   pcr_core_model u_core (.clk_i(clk_i), .addr_i(paddr), .drive_i(pdrv),
      .cpu_addr_o(cpu_addr), .int_data_o(idata), .int_drive_o(idrv),
      .ext_data_o(edata));
   pcr_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_sel_i(4'h1), .wb_we_i(we), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .mode_select_pin_b_i(pinb), .expanded_mode_pin_i(pexp),
      .rom_enable_i(rom_en), .cpu_addr_i(cpu_addr), .int_data_i(idata),
      .int_drive_i(idrv), .ext_data_i(edata), .ram_sel_o(ram_sel),
      .reg_sel_o(reg_sel), .rom_sel_o(rom_sel), .ext_sel_o(ext_sel),
      .cpu_rdata_o(cpu_rdata), .ram_page_select_o(rpage),
      .register_block_page_select_o(gpage), .timer_prescale_select_o(psel),
      .watchdog_rate_select_o(wsel), .timer_tick_o(tick),
      .special_mode_select_o(smode), .protect_window_o(win));
   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk8(input string what, input logic [7:0] e,
                       input logic [7:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask : chk8
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      adr  <= a;
      we   <= w;
      wdat <= {24'h00_0000, d};
      cyc  <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) err_count++;
      rd = wb_dat_o[7:0];
      cyc <= 1'b0;
      we  <= 1'b0;
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(a, 1'b1, d);
   endtask : wr
   task automatic rdchk(input string what, input logic [7:0] a,
                        input logic [7:0] e);
      wb(a, 1'b0, 8'h00);
      chk8(what, e, rd);
   endtask : rdchk
   task automatic do_reset(input logic b, input logic e);
      @(posedge clk_i);
      rst_i <= 1'b1;
      pinb  <= b;
      pexp  <= e;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : do_reset
   // Settle two cycles first so the previous rate cannot leak into the count.
   task automatic count(input int code);
      int c;
      c = 0;
      repeat (2) @(posedge clk_i);
      repeat (64) begin
         @(posedge clk_i);
         #1;
         if (tick === 1'b1) c++;
      end
      chk8("ticks", 8'(64 / DIV[code]), 8'(c));
   endtask : count
   task automatic probe(input logic [15:0] a, input logic d,
                        input logic [3:0] es, input logic [7:0] ed);
      @(posedge clk_i);
      paddr <= a;
      pdrv  <= d;
      repeat (3) @(posedge clk_i);
      #1;
      chk8("decode", {4'h0, es}, {4'h0, reg_sel, ram_sel, rom_sel, ext_sel});
      chk8("cpu data", ed, cpu_rdata);
   endtask : probe
   ////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset(1'b1, 1'b0);
      rdchk("map", MAP_OFS, MAP_RESET);
      chk8("ram page", 8'h00, {4'h0, rpage});
      chk8("reg page", 8'h01, {4'h0, gpage});
      chk8("window", 8'h01, {7'h00, win});
      wr(TM2_OFS, 8'hFF);
      wr(TM2_OFS, 8'h01);
      wr(MAP_OFS, 8'hDC);
      wr(MAP_OFS, 8'h5A);
      wr(OPT_OFS, 8'h02);
      wr(OPT_OFS, 8'h03);
      rdchk("tm2", TM2_OFS, 8'h03);
      rdchk("map", MAP_OFS, 8'hDC);
      rdchk("opt", OPT_OFS, 8'h02);
      chk8("ram page", 8'h0D, {4'h0, rpage});
      chk8("reg page", 8'h0C, {4'h0, gpage});
      chk8("wdog", 8'h02, {6'h00, wsel});
      count(3);
      do_reset(1'b1, 1'b0);
      ce <= 1'b0;
      repeat (100) @(posedge clk_i);
      chk8("frozen", 8'h01, {7'h00, win});
      ce <= 1'b1;
      repeat (70) @(posedge clk_i);
      chk8("window", 8'h00, {7'h00, win});
      rdchk("count", CNT_OFS, {1'b0, WINDOW_CYCLES});
      wr(MAP_OFS, 8'h23);
      wr(TM2_OFS, 8'h02);
      rdchk("map", MAP_OFS, MAP_RESET);
      chk8("prescale", 8'h00, {6'h00, psel});
      do_reset(1'b0, 1'b1);
      chk8("special", 8'h01, {7'h00, smode});
      wr(MAP_OFS, 8'h55);
      wr(MAP_OFS, 8'hFF);
      rdchk("map", MAP_OFS, 8'hFF);
      for (int k = 0; k < 4; k++) begin
         wr(TM2_OFS, 8'(k));
         count(k);
      end
      probe(16'hF010, 1'b1, 4'b1000, 8'h3C);
      probe(16'hF040, 1'b1, 4'b0100, 8'h3C);
      probe(16'hF100, 1'b1, 4'b0010, 8'h3C);
      probe(16'hF003, 1'b1, 4'b0001, 8'h5A);
      probe(16'hF035, 1'b0, 4'b1000, FLOAT_DATA);
      @(posedge clk_i);
      rom_en <= 1'b0;
      probe(16'hF100, 1'b1, 4'b0001, 8'h5A);
      wr(TM2_OFS, 8'h01);
      wr(MODE_OFS, 8'h00);
      @(posedge clk_i);
      chk8("special", 8'h00, {7'h00, smode});
      wr(MAP_OFS, 8'h12);
      rdchk("map", MAP_OFS, 8'hFF);
      rdchk("mode", MODE_OFS, 8'h1A);
      wr(8'h20, 8'h77);
      rdchk("unmapped", 8'h20, 8'h00);
      wrap_up();
   end
   initial begin
      #400000;
      err_count++;
      wrap_up();
   end
endmodule : pcr_top_tb
`default_nettype wire
